// [src/rtwp_pkg.sv]
// Shared constants, types and phase layout for the render-target write payload link
// Assumes both ends compile against this package; no imports are used
package rtwp_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int DW = 32;
	localparam int DWORDS = 8;
	localparam int REG_W = 256;
	localparam int SLOTS = 16;
	localparam int CHANS = 4;
	localparam logic [3:0] HDR_REGS = 4'h2;
	localparam logic [15:0] KEEP_ALL = 16'hffff;
	// Header dword 0 flag positions
	localparam int HDR_DEPTH_BIT = 13;
	localparam int HDR_MASK_BIT = 12;
	localparam int HDR_S0A_BIT = 11;

	// ----------------------------------------
	// Message types
	// ----------------------------------------
	localparam logic [2:0] MT_SIMD16 = 3'h0;
	localparam logic [2:0] MT_REPDATA = 3'h1;
	localparam logic [2:0] MT_DUAL_HI = 3'h2;
	localparam logic [2:0] MT_DUAL_LO = 3'h3;
	localparam logic [2:0] MT_SIMD8_LO = 3'h4;
	localparam logic [2:0] MT_IMG_WRITE = 3'h7;

	localparam logic [1:0] FMT_FLOAT = 2'h0;
	localparam logic [1:0] FMT_SIGNED = 2'h1;
	localparam logic [1:0] FMT_UNSIGNED = 2'h2;

	typedef enum logic [2:0] {PH_HDR, PH_S0A, PH_MASK, PH_COLOR, PH_DEPTH, PH_NONE} rtwp_kind_t;

	typedef struct packed {
		rtwp_kind_t kind;
		logic [1:0] chan;
		logic half;
		logic src;
	} rtwp_phase_t;

	typedef struct packed {
		logic [2:0] mtype;
		logic hdr;
		logic s0a;
		logic sample_keep_mask;
		logic sdepth;
	} rtwp_desc_t;

	// ----------------------------------------
	// Layout helpers
	// ----------------------------------------
	function automatic logic is_simd16(input logic [2:0] mt);
		return (mt == MT_SIMD16) || (mt == MT_REPDATA);
	endfunction

	function automatic logic legal(input rtwp_desc_t d);
		case (d.mtype)
			MT_SIMD16, MT_SIMD8_LO: return 1'b1;
			MT_REPDATA, MT_IMG_WRITE: return !d.s0a && !d.sdepth;
			MT_DUAL_HI, MT_DUAL_LO: return !d.s0a;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [3:0] col_regs(input logic [2:0] mt);
		case (mt)
			MT_SIMD16, MT_DUAL_HI, MT_DUAL_LO: return 4'h8;
			MT_REPDATA: return 4'h1;
			default: return 4'h4;
		endcase
	endfunction

	function automatic logic [3:0] depth_regs(input rtwp_desc_t d);
		if (!d.sdepth || d.mtype == MT_REPDATA)
			return 4'h0;
		return (d.mtype == MT_SIMD16) ? 4'h2 : 4'h1;
	endfunction

	function automatic logic [3:0] s0a_regs(input rtwp_desc_t d);
		if (!d.s0a)
			return 4'h0;
		return (d.mtype == MT_SIMD16) ? 4'h2 : 4'h1;
	endfunction

	function automatic logic [3:0] total_regs(input rtwp_desc_t d);
		return (d.hdr ? HDR_REGS : 4'h0) + s0a_regs(d) + {3'h0, d.sample_keep_mask}
			+ col_regs(d.mtype) + depth_regs(d);
	endfunction

	// What register idx of a message holds
	function automatic rtwp_phase_t phase_at(input rtwp_desc_t d, input logic [3:0] idx);
		rtwp_phase_t ph;
		logic [3:0] p;
		ph = '{kind: PH_NONE, chan: 2'h0, half: 1'b0, src: 1'b0};
		p = idx;
		if (d.hdr && p < HDR_REGS)
		begin
			ph.kind = PH_HDR;
			ph.half = p[0];
			return ph;
		end
		if (d.hdr)
			p = p - HDR_REGS;
		if (p < s0a_regs(d))
		begin
			ph.kind = PH_S0A;
			ph.half = p[0];
			return ph;
		end
		p = p - s0a_regs(d);
		if (d.sample_keep_mask && p == 4'h0)
		begin
			ph.kind = PH_MASK;
			return ph;
		end
		p = p - {3'h0, d.sample_keep_mask};
		if (p < col_regs(d.mtype))
		begin
			ph.kind = PH_COLOR;
			case (d.mtype)
				MT_SIMD16:
				begin
					ph.chan = p[2:1];
					ph.half = p[0];
				end
				MT_DUAL_HI, MT_DUAL_LO:
				begin
					ph.chan = p[1:0];
					ph.src = p[2];
					ph.half = (d.mtype == MT_DUAL_HI);
				end
				default: ph.chan = p[1:0];
			endcase
			return ph;
		end
		p = p - col_regs(d.mtype);
		if (p < depth_regs(d))
		begin
			ph.kind = PH_DEPTH;
			ph.half = (d.mtype == MT_SIMD16) ? p[0] : (d.mtype == MT_DUAL_HI);
		end
		return ph;
	endfunction

endpackage

// [src/rtwp_link_if.sv]
// Link between message sender and payload parser: one 256-bit register per beat
// Assumes a single clock; desc is valid on the beat marked first
`timescale 1ns/100ps
interface rtwp_link_if (
	input wire logic clk, // Core clock
	input wire logic rst // Async reset, active high
);
	logic valid;
	logic ready;
	logic first;
	logic last;
	logic [rtwp_pkg::REG_W-1:0] data;
	rtwp_pkg::rtwp_desc_t desc;

	modport sender (input clk, input rst, input ready,
		output valid, output first, output last, output data, output desc);
	modport receiver (input clk, input rst, input valid, input first, input last,
		input data, input desc, output ready);
endinterface

// [src/rtwp_rx.sv]
// What this block does
// - Zero keep bit suppresses sample colour, depth
// - Ignore keep bits beyond sample count
// - Keep mask follows source-zero alpha registers
// - Two 16-bit masks per dword, odd high
// - SIMD8 uses low or high mask half
// - SIMD16 colour: two registers per channel
// - Colour read as signed, unsigned or float
// - SIMD8 colour: four registers, slot k dword k
// - Replicated colour broadcast to all sixteen pixels
// - Replicated message: colour and mask only
// - Replicated message only to tiled surfaces (refused by rtwp_tx; this parser has no tiling input and does not check it)
// - Header present moves payload to register 2
// - Phase order alpha, mask, colour, depth
// - Dual source layout, half chosen by type
// - Sender uses only legal type/flag sets
// - Source-zero alpha: low slots then high
//
// Payload parser end of the render-target write link.
// Assumes the link interface and one clock; results held until msg_ready.
`timescale 1ns/100ps
module rtwp_rx (
	input wire logic clk, // Core clock
	input wire logic rst, // Async reset, active high
	rtwp_link_if.receiver link, // Register stream from sender
	input wire logic [1:0] surface_fmt, // Colour format of target
	input wire logic [2:0] sample_count_log2, // Log2 of multisample count
	output logic msg_valid, // Parsed message held
	input wire logic msg_ready, // User has taken message
	output logic msg_error, // One-cycle pulse, message dropped
	output rtwp_pkg::rtwp_desc_t msg_desc, // Descriptor of held message
	output logic [1:0] msg_fmt, // Format tag for colour values
	output logic [31:0] color0 [16][4], // Source 0 colour per slot, channel
	output logic [31:0] color1 [16][4], // Source 1 colour per slot, channel
	output logic [31:0] s0_alpha [16], // Source-zero alpha per slot
	output logic [31:0] depth [16], // Source depth per slot
	output logic [15:0] sample_write_en [16] // Per slot sample write enables
);
	localparam int DW = rtwp_pkg::DW;

	if (rtwp_pkg::REG_W != DW * rtwp_pkg::DWORDS)
	begin
		$error("register width must be eight dwords");
	end

	// ----------------------------------------
	// Message tracking
	// ----------------------------------------
	typedef enum logic [1:0] {S_IDLE, S_RECV, S_HOLD} rtwp_rx_state_t;

	rtwp_rx_state_t state_reg;
	rtwp_pkg::rtwp_desc_t desc_reg;
	logic [3:0] idx_reg;
	logic bad_reg;
	logic ready_reg;
	logic [15:0] keep_reg [16];

	rtwp_pkg::rtwp_desc_t desc_use;
	rtwp_pkg::rtwp_phase_t ph;
	logic [3:0] idx_use;
	logic in_msg;
	logic accept;
	logic cur_bad;
	logic [15:0] range_mask;

	assign link.ready = ready_reg;
	assign accept = link.valid && ready_reg;
	assign in_msg = (state_reg == S_RECV) || (state_reg == S_IDLE && link.first);
	assign desc_use = (state_reg == S_IDLE) ? link.desc : desc_reg;
	assign idx_use = (state_reg == S_IDLE) ? 4'h0 : idx_reg;
	assign ph = rtwp_pkg::phase_at(desc_use, idx_use);
	// A new first beat mid-message or a beat past the expected count spoils it
	assign cur_bad = (state_reg == S_RECV && (bad_reg || link.first))
		|| !rtwp_pkg::legal(desc_use)
		|| idx_use >= rtwp_pkg::total_regs(desc_use);
	// Counts above sixteen samples cannot occur; treat them as all kept
	assign range_mask = (sample_count_log2 > 3'h4) ? rtwp_pkg::KEEP_ALL
		: 16'((17'h0_0001 << (5'h01 << sample_count_log2)) - 17'h0_0001);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= S_IDLE;
			idx_reg <= 4'h0;
			bad_reg <= 1'b0;
			ready_reg <= 1'b1;
			msg_valid <= 1'b0;
			msg_error <= 1'b0;
		end
		else
		begin
			msg_error <= 1'b0;
			case (state_reg)
				S_IDLE, S_RECV:
				begin
					if (accept && in_msg)
					begin
						if (!link.last)
						begin
							state_reg <= S_RECV;
							idx_reg <= idx_use + 4'h1;
							bad_reg <= cur_bad;
						end
						else if (cur_bad
							|| idx_use + 4'h1 != rtwp_pkg::total_regs(desc_use))
						begin
							state_reg <= S_IDLE;
							idx_reg <= 4'h0;
							bad_reg <= 1'b0;
							msg_error <= 1'b1;
						end
						else
						begin
							state_reg <= S_HOLD;
							idx_reg <= 4'h0;
							bad_reg <= 1'b0;
							ready_reg <= 1'b0;
							msg_valid <= 1'b1;
						end
					end
				end
				S_HOLD:
				begin
					if (msg_ready)
					begin
						state_reg <= S_IDLE;
						ready_reg <= 1'b1;
						msg_valid <= 1'b0;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			desc_reg <= '0;
		else if (accept && state_reg == S_IDLE && link.first)
			desc_reg <= link.desc;
	end

	// ----------------------------------------
	// Payload unpacking
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int s = 0; s < 16; s++)
			begin
				keep_reg[s] <= rtwp_pkg::KEEP_ALL;
				s0_alpha[s] <= '0;
				depth[s] <= '0;
				for (int c = 0; c < 4; c++)
				begin
					color0[s][c] <= '0;
					color1[s][c] <= '0;
				end
			end
		end
		else if (accept && in_msg && !cur_bad)
		begin
			// Without a mask phase every sample is kept
			if (state_reg == S_IDLE)
				for (int s = 0; s < 16; s++)
					keep_reg[s] <= rtwp_pkg::KEEP_ALL;
			case (ph.kind)
				rtwp_pkg::PH_S0A:
					for (int k = 0; k < 8; k++)
						s0_alpha[{ph.half, 3'(k)}] <= link.data[k*DW +: DW];
				rtwp_pkg::PH_MASK:
					for (int k = 0; k < 8; k++)
					begin
						keep_reg[2*k] <= link.data[k*DW +: 16];
						keep_reg[2*k+1] <= link.data[k*DW+16 +: 16];
					end
				rtwp_pkg::PH_COLOR:
				begin
					if (desc_use.mtype == rtwp_pkg::MT_REPDATA)
					begin
						for (int s = 0; s < 16; s++)
							for (int c = 0; c < 4; c++)
								color0[s][c] <= link.data[c*DW +: DW];
					end
					else
					begin
						for (int k = 0; k < 8; k++)
						begin
							if (ph.src)
								color1[{ph.half, 3'(k)}][ph.chan] <= link.data[k*DW +: DW];
							else
								color0[{ph.half, 3'(k)}][ph.chan] <= link.data[k*DW +: DW];
						end
					end
				end
				rtwp_pkg::PH_DEPTH:
					for (int k = 0; k < 8; k++)
						depth[{ph.half, 3'(k)}] <= link.data[k*DW +: DW];
				default:
				begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Result latch
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			msg_desc <= '0;
			msg_fmt <= rtwp_pkg::FMT_FLOAT;
			for (int s = 0; s < 16; s++)
				sample_write_en[s] <= '0;
		end
		else if (accept && in_msg && link.last)
		begin
			msg_desc <= desc_use;
			msg_fmt <= surface_fmt;
			for (int s = 0; s < 16; s++)
			begin
				// SIMD8 types cover only one half of the slots
				if (rtwp_pkg::is_simd16(desc_use.mtype)
					|| ((s >= 8) == (desc_use.mtype == rtwp_pkg::MT_DUAL_HI)))
					// One-beat message: mask default not yet in keep_reg
					sample_write_en[s] <= ((state_reg == S_IDLE) ? rtwp_pkg::KEEP_ALL
						: keep_reg[s]) & range_mask;
				else
					sample_write_en[s] <= '0;
			end
		end
	end

endmodule

// [src/rtwp_tx.sv]
// Sender end of the render-target write link: builds payload registers from slot data
// Assumes the link interface and one clock; refuses illegal requests
`timescale 1ns/100ps
module rtwp_tx (
	input wire logic clk, // Core clock
	input wire logic rst, // Async reset, active high
	rtwp_link_if.sender link, // Register stream to parser
	input wire logic req_valid, // Send request
	output logic req_ready, // Ready for a request
	output logic req_refused, // One-cycle pulse, request illegal
	input wire rtwp_pkg::rtwp_desc_t req_desc, // Type and presence flags
	input wire logic req_tiled, // Target surface is tiled
	input wire logic [31:0] req_color0 [16][4], // Source 0 colour
	input wire logic [31:0] req_color1 [16][4], // Source 1 colour
	input wire logic [31:0] req_s0_alpha [16], // Source-zero alpha
	input wire logic [31:0] req_depth [16], // Source depth
	input wire logic [15:0] req_keep [16] // Sample keep masks
);
	localparam int DW = rtwp_pkg::DW;

	typedef enum logic [1:0] {S_IDLE, S_LOAD, S_SEND} rtwp_tx_state_t;

	rtwp_tx_state_t state_reg;
	rtwp_pkg::rtwp_desc_t desc_reg;
	logic [3:0] idx_reg;
	logic [31:0] c0_reg [16][4];
	logic [31:0] c1_reg [16][4];
	logic [31:0] a_reg [16];
	logic [31:0] z_reg [16];
	logic [15:0] k_reg [16];
	logic valid_reg;
	logic first_reg;
	logic last_reg;
	logic [rtwp_pkg::REG_W-1:0] data_reg;

	logic [3:0] nidx;
	rtwp_pkg::rtwp_phase_t ph;
	logic [rtwp_pkg::REG_W-1:0] beat;

	assign link.valid = valid_reg;
	assign link.first = first_reg;
	assign link.last = last_reg;
	assign link.data = data_reg;
	assign link.desc = desc_reg;
	assign nidx = (state_reg == S_LOAD) ? 4'h0 : idx_reg + 4'h1;
	assign ph = rtwp_pkg::phase_at(desc_reg, nidx);

	// ----------------------------------------
	// Register builder
	// ----------------------------------------
	always_comb
	begin
		beat = '0;
		case (ph.kind)
			rtwp_pkg::PH_HDR:
				if (!ph.half)
				begin
					beat[rtwp_pkg::HDR_DEPTH_BIT] = desc_reg.sdepth;
					beat[rtwp_pkg::HDR_MASK_BIT] = desc_reg.sample_keep_mask;
					beat[rtwp_pkg::HDR_S0A_BIT] = desc_reg.s0a;
				end
			rtwp_pkg::PH_S0A:
				for (int k = 0; k < 8; k++)
					beat[k*DW +: DW] = a_reg[{ph.half, 3'(k)}];
			rtwp_pkg::PH_MASK:
				for (int k = 0; k < 8; k++)
					beat[k*DW +: DW] = {k_reg[2*k+1], k_reg[2*k]};
			rtwp_pkg::PH_COLOR:
				if (desc_reg.mtype == rtwp_pkg::MT_REPDATA)
				begin
					for (int c = 0; c < 4; c++)
						beat[c*DW +: DW] = c0_reg[0][c];
				end
				else
				begin
					for (int k = 0; k < 8; k++)
						beat[k*DW +: DW] = ph.src ? c1_reg[{ph.half, 3'(k)}][ph.chan]
							: c0_reg[{ph.half, 3'(k)}][ph.chan];
				end
			rtwp_pkg::PH_DEPTH:
				for (int k = 0; k < 8; k++)
					beat[k*DW +: DW] = z_reg[{ph.half, 3'(k)}];
			default: beat = '0;
		endcase
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= S_IDLE;
			desc_reg <= '0;
			idx_reg <= 4'h0;
			req_ready <= 1'b1;
			req_refused <= 1'b0;
			valid_reg <= 1'b0;
			first_reg <= 1'b0;
			last_reg <= 1'b0;
			data_reg <= '0;
		end
		else
		begin
			req_refused <= 1'b0;
			case (state_reg)
				S_IDLE:
					if (req_valid)
					begin
						// Replicated data only legal to tiled targets
						if (!rtwp_pkg::legal(req_desc)
							|| (req_desc.mtype == rtwp_pkg::MT_REPDATA && !req_tiled))
							req_refused <= 1'b1;
						else
						begin
							desc_reg <= req_desc;
							req_ready <= 1'b0;
							state_reg <= S_LOAD;
						end
					end
				S_LOAD, S_SEND:
					if (state_reg == S_LOAD || link.ready)
					begin
						if (state_reg == S_SEND && last_reg)
						begin
							valid_reg <= 1'b0;
							last_reg <= 1'b0;
							req_ready <= 1'b1;
							state_reg <= S_IDLE;
						end
						else
						begin
							valid_reg <= 1'b1;
							idx_reg <= nidx;
							data_reg <= beat;
							first_reg <= (nidx == 4'h0);
							last_reg <= (nidx + 4'h1 == rtwp_pkg::total_regs(desc_reg));
							state_reg <= S_SEND;
						end
					end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int s = 0; s < 16; s++)
			begin
				a_reg[s] <= '0;
				z_reg[s] <= '0;
				k_reg[s] <= rtwp_pkg::KEEP_ALL;
				for (int c = 0; c < 4; c++)
				begin
					c0_reg[s][c] <= '0;
					c1_reg[s][c] <= '0;
				end
			end
		end
		else if (state_reg == S_IDLE && req_valid)
		begin
			a_reg <= req_s0_alpha;
			z_reg <= req_depth;
			k_reg <= req_keep;
			c0_reg <= req_color0;
			c1_reg <= req_color1;
		end
	end

endmodule

// [verification/rtwp_chk_sva.sv]
// Checker for the link between sender and parser of render-target write payloads
// Assumes it sits beside the one link whose both ends are design modules
`timescale 1ns/100ps
module rtwp_chk_sva (
	input wire logic clk, // Core clock
	input wire logic rst, // Async reset, active high
	input wire logic valid, // Beat offered
	input wire logic ready, // Parser takes beats
	input wire logic first, // First register of message
	input wire logic last, // Last register of message
	input wire logic [rtwp_pkg::REG_W-1:0] data, // One message register
	input wire rtwp_pkg::rtwp_desc_t desc // Type and presence flags
);
	logic take;
	logic [3:0] cnt_reg;
	logic [3:0] need_reg;

	assign take = valid && ready;

	// ----------------------------------------
	// Expected register count of a message
	// ----------------------------------------
	function automatic logic [3:0] nregs(input rtwp_pkg::rtwp_desc_t d);
		logic wide;
		wide = d.mtype == 3'h0;
		return (d.hdr ? 4'h2 : 4'h0) + (d.s0a ? (wide ? 4'h2 : 4'h1) : 4'h0) + {3'h0, d.sample_keep_mask}
			+ ((d.mtype inside {3'h0, 3'h2, 3'h3}) ? 4'h8 : ((d.mtype == 3'h1) ? 4'h1 : 4'h4))
			+ (d.sdepth ? (wide ? 4'h2 : 4'h1) : 4'h0);
	endfunction

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_reg <= 4'h0;
		else if (take)
			cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			need_reg <= 4'h0;
		else if (take && first)
			need_reg <= nregs(desc);
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	hold_beat_a: assert property (valid && !ready |=> valid && $stable(data) && $stable(desc)
		&& $stable(first) && $stable(last)) else $error("Beat changed before it was taken");
	type_legal_a: assert property (valid && first |-> !(desc.mtype inside {3'h5, 3'h6})
		&& !(desc.s0a && !(desc.mtype inside {3'h0, 3'h4}))) else $error("Illegal type sent");
	rep_only_color_a: assert property (valid && first && desc.mtype == rtwp_pkg::MT_REPDATA
		|-> !desc.sdepth && !desc.s0a) else $error("Replicated message with extra phases");
	hdr_flags_a: assert property (valid && first && desc.hdr
		|-> data[13:11] == {desc.sdepth, desc.sample_keep_mask, desc.s0a}) else $error("Header flags wrong");
	beat_count_a: assert property (take && last
		|-> (cnt_reg + 4'h1) == (first ? nregs(desc) : need_reg)) else $error("Beat count wrong");
	no_mid_first_a: assert property (valid && cnt_reg != 4'h0 |-> !first)
		else $error("First beat inside a message");
	ready_drop_a: assert property (take && last |=> !ready ##1 !take)
		else $error("Parser took beats while holding a result");
	one_msg_a: assert property (take && last |=> !valid)
		else $error("Next message started without a gap");

	cover property (take && first && desc.mtype == rtwp_pkg::MT_REPDATA);
	cover property (take && first && desc.mtype == rtwp_pkg::MT_DUAL_HI && desc.sdepth);
	cover property (take && first && desc.mtype == 3'h0 && desc.s0a && desc.sample_keep_mask && desc.sdepth);
endmodule

// [verification/render_target_write_payload_parser_tb.sv]
// Bench: sender and parser joined by one link, a second parser on a hand-driven link
// Assumes the package, link interface and both ends are compiled first
`timescale 1ns/100ps
module render_target_write_payload_parser_tb;
	typedef struct {
		rtwp_pkg::rtwp_desc_t d;
		logic [1:0] f;
		logic [31:0] c0 [16][4];
		logic [31:0] c1 [16][4];
		logic [31:0] a [16];
		logic [31:0] z [16];
		logic [15:0] en [16];
		logic [15:0] cov;
	} rtwp_exp_t;
	logic clk, rst, req_valid, req_ready, req_refused, req_tiled, msg_ready, msg_valid, msg_error;
	logic err2;
	rtwp_pkg::rtwp_desc_t req_desc, msg_desc;
	logic [31:0] c0 [16][4];
	logic [31:0] c1 [16][4];
	logic [31:0] s0a [16];
	logic [31:0] dep [16];
	logic [15:0] keep [16];
	logic [1:0] fmt, msg_fmt;
	logic [2:0] scl;
	logic [31:0] o_c0 [16][4];
	logic [31:0] o_c1 [16][4];
	logic [31:0] o_a [16];
	logic [31:0] o_z [16];
	logic [15:0] o_en [16];
	logic [31:0] seed_reg;
	logic [2:0] mts [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	rtwp_exp_t exp_q [$];
	rtwp_exp_t mon_e;
	int bad_count = 0;
	int check_count = 0;

	rtwp_link_if link (.clk(clk), .rst(rst));
	rtwp_link_if link2 (.clk(clk), .rst(rst));
	rtwp_tx rtwp_tx_i (.clk(clk), .rst(rst), .link(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_refused(req_refused), .req_desc(req_desc),
		.req_tiled(req_tiled), .req_color0(c0), .req_color1(c1), .req_s0_alpha(s0a),
		.req_depth(dep), .req_keep(keep));
	rtwp_rx rtwp_rx_i (.clk(clk), .rst(rst), .link(link), .surface_fmt(fmt),
		.sample_count_log2(scl), .msg_valid(msg_valid), .msg_ready(msg_ready),
		.msg_error(msg_error), .msg_desc(msg_desc), .msg_fmt(msg_fmt), .color0(o_c0),
		.color1(o_c1), .s0_alpha(o_a), .depth(o_z), .sample_write_en(o_en));
	// Fault end: the bench plays a sender that breaks the protocol
	rtwp_rx rtwp_rx_fault_i (.clk(clk), .rst(rst), .link(link2), .surface_fmt(2'h0),
		.sample_count_log2(3'h0), .msg_valid(), .msg_ready(1'b1), .msg_error(err2),
		.msg_desc(), .msg_fmt(), .color0(), .color1(), .s0_alpha(), .depth(),
		.sample_write_en());
	rtwp_chk_sva rtwp_chk_sva_i (.clk(clk), .rst(rst), .valid(link.valid), .ready(link.ready),
		.first(link.first), .last(link.last), .data(link.data), .desc(link.desc));

	initial
	begin
		clk = 1'b0;
		forever
			#2.5 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed_reg = {seed_reg[30:0], seed_reg[31] ^ seed_reg[21] ^ seed_reg[1] ^ seed_reg[0]};
		return seed_reg;
	endfunction

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_en(input logic [15:0] got, input logic [15:0] exp);
		cmp_word({16'h0000, got}, {16'h0000, exp});
	endtask

	task automatic cmp_flag(input logic got, input logic exp);
		cmp_word({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic hang();
		bad_count++;
		$display("Error at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
		give_verdict();
	endtask

	task automatic fill(input rtwp_pkg::rtwp_desc_t d);
		fmt = 2'(rnd() % 3);
		scl = 3'(rnd() % 5);
		for (int s = 0; s < 16; s++)
		begin
			s0a[s] = rnd();
			dep[s] = rnd();
			keep[s] = 16'(rnd());
			for (int c = 0; c < 4; c++)
			begin
				// Broadcast source: every slot carries the same colour
				c0[s][c] = (d.mtype == rtwp_pkg::MT_REPDATA && s > 0) ? c0[0][c] : rnd();
				c1[s][c] = rnd();
			end
		end
	endtask

	task automatic send(input rtwp_pkg::rtwp_desc_t d, input logic tiled, input logic refuse);
		rtwp_exp_t e;
		logic [16:0] smp;
		@(posedge clk);
		#1;
		for (int n = 0; req_ready !== 1'b1; n++)
		begin
			if (n > 300)
				hang();
			@(posedge clk);
			#1;
		end
		fill(d);
		req_desc = d;
		req_tiled = tiled;
		smp = (17'h0_0001 << (5'h01 << scl)) - 17'h0_0001;
		e.d = d;
		e.f = fmt;
		e.c0 = c0;
		e.c1 = c1;
		e.a = s0a;
		e.z = dep;
		e.cov = (d.mtype inside {3'h0, 3'h1}) ? 16'hffff : ((d.mtype == 3'h2) ? 16'hff00 : 16'h00ff);
		for (int s = 0; s < 16; s++)
			e.en[s] = e.cov[s] ? ((d.sample_keep_mask ? keep[s] : 16'hffff) & smp[15:0]) : 16'h0000;
		req_valid = 1'b1;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		cmp_flag(req_refused, refuse);
		if (!refuse)
			exp_q.push_back(e);
	endtask

	task automatic beat2(input rtwp_pkg::rtwp_desc_t d, input logic f, input logic l);
		link2.desc = d;
		link2.first = f;
		link2.last = l;
		link2.data = {8{rnd()}};
		link2.valid = 1'b1;
		for (int n = 0; link2.ready !== 1'b1; n++)
		begin
			if (n > 59)
				hang();
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
	endtask

	task automatic err_wait();
		link2.valid = 1'b0;
		for (int n = 0; err2 !== 1'b1 && n < 4; n++)
		begin
			@(posedge clk);
			#1;
		end
		cmp_flag(err2, 1'b1);
		@(posedge clk);
		#1;
	endtask

	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge clk)
	begin
		#1;
		msg_ready = 1'(rnd() >> 5);
	end

	// Sampled mid-cycle, where the beat and the result handshake stand settled
	always @(negedge clk)
	begin
		if (msg_error)
			cmp_flag(msg_error, 1'b0);
		if (link.valid && link.ready && link.first && link.desc.sample_keep_mask && !link.desc.hdr
			&& !link.desc.s0a)
			cmp_word(link.data[31:0], {keep[1], keep[0]});
		if (msg_valid && msg_ready)
		begin
			if (exp_q.size() == 0)
				cmp_flag(1'b1, 1'b0);
			else
			begin
				mon_e = exp_q.pop_front();
				cmp_word(32'(msg_desc), 32'(mon_e.d));
				cmp_word(32'(msg_fmt), 32'(mon_e.f));
				for (int s = 0; s < 16; s++)
				begin
					cmp_en(o_en[s], mon_e.en[s]);
					for (int c = 0; c < 4 && mon_e.cov[s]; c++)
					begin
						cmp_word(o_c0[s][c], mon_e.c0[s][c]);
						if (mon_e.d.mtype inside {3'h2, 3'h3})
							cmp_word(o_c1[s][c], mon_e.c1[s][c]);
					end
					if (mon_e.cov[s] && mon_e.d.s0a)
						cmp_word(o_a[s], mon_e.a[s]);
					if (mon_e.cov[s] && mon_e.d.sdepth)
						cmp_word(o_z[s], mon_e.z[s]);
				end
			end
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rtwp_pkg::rtwp_desc_t d;
		seed_reg = 32'h0000_6894;
		rst = 1'b1;
		req_valid = 1'b0;
		req_desc = '0;
		req_tiled = 1'b1;
		link2.valid = 1'b0;
		link2.first = 1'b0;
		link2.last = 1'b0;
		link2.data = '0;
		link2.desc = '0;
		fill('0);
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 6; i++)
			for (int f = 0; f < 8; f++)
			begin
				d = {mts[i], 1'(rnd()), 3'(f)};
				// Only combinations from the legal sequence table
				if (!(d.s0a && !(d.mtype inside {3'h0, 3'h4})) && !(d.sdepth && d.mtype inside {3'h1, 3'h7}))
					send(d, 1'b1, 1'b0);
			end
		$display("Test legal combinations done");
		send({3'h5, 4'h0}, 1'b1, 1'b1);
		send({3'h6, 4'h5}, 1'b1, 1'b1);
		send({3'h2, 4'h4}, 1'b1, 1'b1);
		send({3'h1, 4'h2}, 1'b0, 1'b1);
		send({3'h1, 4'h1}, 1'b1, 1'b1);
		$display("Test refused requests done");
		beat2({3'h5, 4'h0}, 1'b1, 1'b1);
		err_wait();
		beat2({3'h4, 4'h0}, 1'b1, 1'b0);
		beat2({3'h4, 4'h0}, 1'b0, 1'b1);
		err_wait();
		$display("Test faulty sender done");
		for (int n = 0; exp_q.size() != 0; n++)
		begin
			if (n > 500)
				hang();
			@(posedge clk);
		end
		give_verdict();
	end
endmodule
